// ==== dv/lds_connector_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// control connector equipment
// ----------------------------------------
module lds_connector_model (
   input wire logic pclk,
   input wire lds_pkg::lds_out_type sig_out
);
   logic [1:0] codes[$];
   logic [1:0] last_code = 2'h0;
   logic trig_d = 1'h0;
   int pulses = 0;
   int high_cycles = 0;
   // sampled every rising edge so a one-cycle step code is still logged
   always @(posedge pclk) begin
      if (sig_out.code !== last_code) begin
         codes.push_back(sig_out.code);
      end
      if (sig_out.trig === 1'h1 && trig_d !== 1'h1) begin
         pulses++;
      end
      if (sig_out.trig === 1'h1) begin
         high_cycles++;
      end
      last_code = sig_out.code;
      trig_d = sig_out.trig;
   end
   task clear_log;
      codes.delete();
      pulses = 0;
      high_cycles = 0;
   endtask
endmodule
`default_nettype wire

// ==== dv/lds_sequencer_sva.sv ====
`timescale 1ns/100ps
`include "lds_cfg.svh"
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module lds_sequencer_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic output_on,
   input wire logic run_active,
   input wire logic balanced_mode,
   input wire logic internal_sine_src
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_ctrl_wr;
      psel && penable && pready && pwrite && (paddr == `LDS_OFF_CTRL);
   endsequence
   sequence s_start;
      s_ctrl_wr ##0 pwdata[`LDS_CMD_START];
   endsequence
   sequence s_exit;
      s_ctrl_wr ##0 pwdata[`LDS_CMD_EXIT];
   endsequence
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_ready_after_access;
      pready |-> psel && penable && $past(psel && penable);
   endproperty
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   property p_fixed_modes;
      balanced_mode && internal_sine_src;
   endproperty
   property p_idle_holds;
      !run_active && !(psel && penable && pready && pwrite && paddr == `LDS_OFF_CTRL && pwdata[`LDS_CMD_START])
      |=> !run_active;
   endproperty
   property p_start_ignored;
      s_start ##0 (!output_on && !run_active) |=> !run_active;
   endproperty
   property p_start_taken;
      s_start ##0 (output_on && !run_active) |=> run_active;
   endproperty
   property p_exit_idle;
      s_exit ##0 (run_active && pwdata[`LDS_CTRL_OUT_EN]) |=> !run_active && output_on;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   a_ready_after_access: assert property (p_ready_after_access) else $error("ready without access");
   a_err_with_ready: assert property (p_err_with_ready) else $error("slverr without ready");
   a_fixed_modes: assert property (p_fixed_modes) else $error("mode outputs not fixed");
   a_idle_holds: assert property (p_idle_holds) else $error("left idle without start");
   a_start_ignored: assert property (p_start_ignored) else $error("start taken with output off");
   a_start_taken: assert property (p_start_taken) else $error("start not taken");
   a_exit_idle: assert property (p_exit_idle) else $error("exit did not reach idle");
endmodule
bind lds_sequencer lds_sequencer_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .output_on(output_on),
   .run_active(run_active), .balanced_mode(balanced_mode), .internal_sine_src(internal_sine_src));
`default_nettype wire

// ==== dv/test_line_disturbance_step_sequencer.sv ====
`timescale 1ns/100ps
`include "lds_cfg.svh"
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s exp=%0h got=%0h", n, e, g); end end
module test_line_disturbance_step_sequencer;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, output_on, run_active, balanced_mode, internal_sine_src, err;
   lds_pkg::lds_out_type sig_out;
   int bad_count = 0;
   int num_checks = 0;
   always #25 pclk = ~pclk;
   lds_sequencer #(.MS_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sig_out(sig_out), .output_on(output_on), .run_active(run_active),
      .balanced_mode(balanced_mode), .internal_sine_src(internal_sine_src));
   lds_connector_model i_conn (.pclk(pclk), .sig_out(sig_out));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1) bad_count++;
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task rd(input string s, input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      `CHK(s, e, q)
   endtask
   task run(input logic [31:0] c, input logic [1:0] e[$], input int p);
      int n;
      n = 0;
      i_conn.clear_log();
      wr(`LDS_OFF_CTRL, c);
      while (run_active !== 1'h0 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      `CHK("done", 1'h0, run_active)
      repeat (2) @(posedge pclk);
      `CHK("codes", e.size(), i_conn.codes.size())
      foreach (e[i]) `CHK("code", e[i], i_conn.codes[i])
      `CHK("pulses", p, i_conn.pulses)
      `CHK("width", 3 * p, i_conn.high_cycles)
   endtask
   task tally_and_finish;
      if (bad_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      `CHK("freq", 16'h0100, sig_out.freq)
      `CHK("modes", 1'h1, balanced_mode & internal_sine_src)
      rd("s1ctl", 12'h050, 32'h0);
      apb(1'h0, 12'h04C, 32'h0);
      `CHK("err", 1'h1, err)
      `CHK("rdz", 32'h0, q)
      wr(`LDS_OFF_REPEAT, 32'h0000FFFF);
      rd("rep", `LDS_OFF_REPEAT, 32'h0000270F);
      wr(12'h040, 32'h0000001F);
      rd("s0ctl", 12'h040, 32'h00000003);
      wr(12'h064, 32'h12345678);
      rd("s2vf", 12'h064, 32'h01000000);
      wr(12'h050, 32'h00050005);
      wr(`LDS_OFF_CTRL, 32'h00000400);
      rd("clr", 12'h050, 32'h0);
      wr(`LDS_OFF_CTRL, 32'h00000100);
      rd("stat", `LDS_OFF_STATUS, 32'h1);
      wr(12'h050, 32'h00020005);
      wr(12'h060, 32'h00000002);
      wr(12'h070, 32'h00010003);
      wr(12'h080, 32'h00020002);
      wr(12'h090, 32'h00010001);
      wr(`LDS_OFF_TRIGW, 32'h3);
      wr(`LDS_OFF_REPEAT, 32'h1);
      wr(`LDS_OFF_CTRL, 32'h00000803);
      wr(`LDS_OFF_CTRL, 32'h0000000B);
      run(32'h0000010B, '{2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0}, 2);
      wr(`LDS_OFF_CTRL, 32'h0000080A);
      run(32'h0000010A, '{2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0}, 1);
      wr(`LDS_OFF_REPEAT, 32'h0);
      wr(`LDS_OFF_CTRL, 32'h0000080B);
      wr(`LDS_OFF_CTRL, 32'h0000010B);
      repeat (200) @(posedge pclk);
      `CHK("endless", 1'h1, run_active)
      wr(`LDS_OFF_CTRL, 32'h0000020B);
      `CHK("exit", 1'h0, run_active)
      `CHK("on", 1'h1, output_on)
      wr(12'h044, 32'h01000077);
      `CHK("edit", 16'h0000, sig_out.volt)
      wr(12'h054, 32'h01000064);
      wr(12'h050, 32'h00000005);
      wr(12'h060, 32'h00020002);
      wr(`LDS_OFF_CTRL, 32'h00000808);
      wr(`LDS_OFF_CTRL, 32'h00000108);
      repeat (6000) @(posedge pclk);
      `CHK("ramp", 16'h0032, sig_out.volt)
      rd("fall", `LDS_OFF_STATUS, 32'h00000104);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      `CHK("rst", 1'h0, run_active)
      rd("s1vf", 12'h054, 32'h01000000);
      tally_and_finish();
   end
   initial begin
      #1000000;
      bad_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ==== logic/lds_cfg.svh ====
`ifndef LDS_CFG_SVH
`define LDS_CFG_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define LDS_OFF_CTRL 12'h000
`define LDS_OFF_REPEAT 12'h004
`define LDS_OFF_TRIGW 12'h008
`define LDS_OFF_STATUS 12'h00C
`define LDS_OFF_STEP_BASE 12'h040
`define LDS_OFF_STEP_END 12'h0A0
`define LDS_STEP_SHIFT 4
`define LDS_STEP_WORD_CTL 2'h0
`define LDS_STEP_WORD_VF 2'h1
`define LDS_STEP_WORD_ANG 2'h2

// ----------------------------------------
// control register fields
// ----------------------------------------
`define LDS_CTRL_REPEAT_EN 0
`define LDS_CTRL_UNIT_MS 1
`define LDS_CTRL_TRIG_POL 2
`define LDS_CTRL_OUT_EN 3
`define LDS_CMD_START 8
`define LDS_CMD_EXIT 9
`define LDS_CMD_CLEAR 10
`define LDS_CMD_COMPILE 11

// ----------------------------------------
// step word and status register fields
// ----------------------------------------
`define LDS_STEP_CODE_LSB 0
`define LDS_STEP_TRIG_BIT 2
`define LDS_STEP_ENTRY_BIT 3
`define LDS_STEP_EXIT_BIT 4
`define LDS_STEP_HI_LSB 16
`define LDS_STATUS_RUN_BIT 8
`define LDS_STATUS_WAIT_BIT 9
`define LDS_STATUS_REP_LSB 16

// ----------------------------------------
// reset and factory values
// ----------------------------------------
`define LDS_DEF_CODE 2'h0
`define LDS_DEF_DUR 16'h0000
`define LDS_DEF_VOLT 16'h0000
`define LDS_DEF_FREQ 16'h0100
`define LDS_DEF_ANGLE 16'h0000
`define LDS_DEF_TRIGW 16'h0001
`define LDS_DEF_REPEAT 14'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define LDS_CLK_PERIOD_NS 50
`define LDS_MS_NS 1000000
`define LDS_MS_CYCLES (`LDS_MS_NS / `LDS_CLK_PERIOD_NS)
`define LDS_MS_PER_S 1000
`define LDS_REPEAT_MAX 9999

`endif

// ==== logic/lds_pkg.sv ====
`default_nettype none
package lds_pkg;

   typedef enum logic [5:0] {
      LDS_IDLE = 6'h01,
      LDS_PRE = 6'h02,
      LDS_FALL = 6'h04,
      LDS_FAULT = 6'h08,
      LDS_RECOV = 6'h10,
      LDS_POST = 6'h20
   } lds_state_type;

   typedef struct packed {
      logic [1:0] code;
      logic trig_en;
      logic entry_en;
      logic exit_en;
      logic [15:0] duration;
      logic [15:0] volt;
      logic [15:0] freq;
      logic [15:0] entry_ang;
      logic [15:0] exit_ang;
   } lds_step_type;

   typedef struct packed {
      logic [1:0] code;
      logic trig;
      logic [15:0] volt;
      logic [15:0] freq;
      logic [15:0] phase;
   } lds_out_type;

endpackage
`default_nettype wire

// ==== logic/lds_sequencer.sv ====
// Notes on behaviour
// - idle is the standby step; run end returns there unless repeating endlessly.
// - steps run idle, pre-fault, fall ramp, fault, recovery ramp, post-fault.
// - zero ramp duration passes straight through, voltage and frequency jump.
// - nonzero ramp sweeps voltage and frequency linearly between neighbour steps.
// - ramp steps keep only duration, trigger enable and code.
// - exit during a run goes to idle at once; output stays enabled; code reloads it from LDS_CTRL_OUT_EN of the exit write.
// - repeat count programmable 1 to 9999; zero with repeat means endless.
// - with repeat, the series runs repeat count plus one times.
// - without repeat, the series runs exactly once.
// - entry angle enabled loads programmed phase; otherwise phase continues.
// - entry and exit alignment only on pre-fault, fault and post-fault.
// - exit angle enabled holds the step after expiry until phase reached.
// - exit angle disabled advances on expiry regardless of phase.
// - trigger pulse on entry of enabled steps, global polarity and width.
// - idle never triggers and its trigger enable is not settable.
// - every step, idle too, drives its 2-bit code on the connector.
// - duration unit selectable seconds or milliseconds for all steps.
// - clear command restores all step parameters to factory defaults.
// - configuration is volatile; reset brings every parameter to default.
// - output in edit drives idle state of last compile, not edits.
// - polyphase always balanced, waveform fixed to internal sine source.
// - start is ignored while the output is disabled.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "lds_cfg.svh"
`default_nettype none

module lds_sequencer #(
   parameter int unsigned MS_CYCLES = `LDS_MS_CYCLES,
   parameter int unsigned REPEAT_MAX = `LDS_REPEAT_MAX
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output var lds_pkg::lds_out_type sig_out,
   output logic output_on,
   output logic run_active,
   output logic balanced_mode,
   output logic internal_sine_src
);

   localparam int unsigned MSW = $clog2(MS_CYCLES);

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (MS_CYCLES < 2) begin : g_bad_ms
      $error("MS_CYCLES must be at least 2");
   end
   if (REPEAT_MAX < 1 || REPEAT_MAX > 16383) begin : g_bad_rep
      $error("REPEAT_MAX must fit 14 bits");
   end

   localparam lds_pkg::lds_step_type STEP_DEF = '{
      code: `LDS_DEF_CODE, trig_en: 1'b0, entry_en: 1'b0, exit_en: 1'b0,
      duration: `LDS_DEF_DUR, volt: `LDS_DEF_VOLT, freq: `LDS_DEF_FREQ,
      entry_ang: `LDS_DEF_ANGLE, exit_ang: `LDS_DEF_ANGLE};

   // forces the fields that a step may not carry
   function automatic lds_pkg::lds_step_type sanitize(input logic [2:0] idx,
                                                      input lds_pkg::lds_step_type c);
      lds_pkg::lds_step_type r;
      r = c;
      if (idx == 3'h0) begin
         r.trig_en = 1'b0;
      end
      if (idx != 3'h1 && idx != 3'h3 && idx != 3'h5) begin
         r.entry_en = 1'b0;
         r.exit_en = 1'b0;
         r.entry_ang = `LDS_DEF_ANGLE;
         r.exit_ang = `LDS_DEF_ANGLE;
      end
      if (idx == 3'h2 || idx == 3'h4 || idx == 3'h5) begin
         r.volt = `LDS_DEF_VOLT;
         r.freq = `LDS_DEF_FREQ;
      end
      return r;
   endfunction

   function automatic logic [2:0] step_idx(input lds_pkg::lds_state_type s);
      logic [2:0] r;
      r = 3'h0;
      unique case (s)
         lds_pkg::LDS_IDLE: r = 3'h0;
         lds_pkg::LDS_PRE: r = 3'h1;
         lds_pkg::LDS_FALL: r = 3'h2;
         lds_pkg::LDS_FAULT: r = 3'h3;
         lds_pkg::LDS_RECOV: r = 3'h4;
         lds_pkg::LDS_POST: r = 3'h5;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // register file and apb slave
   // ----------------------------------------
   lds_pkg::lds_step_type edit_reg [0:5];
   lds_pkg::lds_step_type edit_next [0:5];
   lds_pkg::lds_step_type act_reg [0:5];
   lds_pkg::lds_step_type act_next [0:5];
   logic repeat_en_reg, repeat_en_next;
   logic unit_ms_reg, unit_ms_next;
   logic trig_pol_reg, trig_pol_next;
   logic out_en_reg, out_en_next;
   logic [13:0] repeat_cnt_reg, repeat_cnt_next;
   logic [15:0] trig_w_reg, trig_w_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic start_cmd, exit_cmd;
   lds_pkg::lds_state_type state_reg, state_next;
   logic wait_reg, wait_next;
   logic [13:0] rep_reg, rep_next;

   logic wr_fire, step_hit, ctrl_hit, known;
   logic [2:0] wr_idx;
   logic [1:0] wr_word;
   logic [11:0] step_off;
   lds_pkg::lds_step_type sel_cfg;

   always_comb begin
      step_off = paddr - `LDS_OFF_STEP_BASE;
      wr_idx = step_off[6:4];
      wr_word = step_off[3:2];
      step_hit = paddr >= `LDS_OFF_STEP_BASE && paddr < `LDS_OFF_STEP_END && wr_word != 2'h3
                 && paddr[1:0] == 2'h0;
      ctrl_hit = paddr == `LDS_OFF_CTRL;
      known = step_hit || ctrl_hit || paddr == `LDS_OFF_REPEAT || paddr == `LDS_OFF_TRIGW
              || paddr == `LDS_OFF_STATUS;
      wr_fire = psel && penable && pready_reg && pwrite && known;
      start_cmd = wr_fire && ctrl_hit && pwdata[`LDS_CMD_START];
      exit_cmd = wr_fire && ctrl_hit && pwdata[`LDS_CMD_EXIT];
      sel_cfg = edit_reg[step_hit ? wr_idx : 3'h0];
   end

   always_comb begin
      lds_pkg::lds_step_type w;
      w = sel_cfg;
      edit_next = edit_reg;
      act_next = act_reg;
      repeat_en_next = repeat_en_reg;
      unit_ms_next = unit_ms_reg;
      trig_pol_next = trig_pol_reg;
      out_en_next = out_en_reg;
      repeat_cnt_next = repeat_cnt_reg;
      trig_w_next = trig_w_reg;
      // answer in the second access cycle so read data is always a flop
      pready_next = psel && penable && !pready_reg;
      pslverr_next = psel && penable && !pready_reg && !known;
      prdata_next = prdata_reg;
      if (psel && penable && !pready_reg) begin
         prdata_next = 32'h0000_0000;
         if (ctrl_hit) begin
            prdata_next[`LDS_CTRL_REPEAT_EN] = repeat_en_reg;
            prdata_next[`LDS_CTRL_UNIT_MS] = unit_ms_reg;
            prdata_next[`LDS_CTRL_TRIG_POL] = trig_pol_reg;
            prdata_next[`LDS_CTRL_OUT_EN] = out_en_reg;
         end else if (paddr == `LDS_OFF_REPEAT) begin
            prdata_next[13:0] = repeat_cnt_reg;
         end else if (paddr == `LDS_OFF_TRIGW) begin
            prdata_next[15:0] = trig_w_reg;
         end else if (paddr == `LDS_OFF_STATUS) begin
            prdata_next[5:0] = state_reg;
            prdata_next[`LDS_STATUS_RUN_BIT] = state_reg != lds_pkg::LDS_IDLE;
            prdata_next[`LDS_STATUS_WAIT_BIT] = wait_reg;
            prdata_next[`LDS_STATUS_REP_LSB +: 14] = rep_reg;
         end else if (step_hit) begin
            unique case (wr_word)
               `LDS_STEP_WORD_CTL:
                  prdata_next = {sel_cfg.duration, 11'h000, sel_cfg.exit_en, sel_cfg.entry_en,
                                 sel_cfg.trig_en, sel_cfg.code};
               `LDS_STEP_WORD_VF: prdata_next = {sel_cfg.freq, sel_cfg.volt};
               default: prdata_next = {sel_cfg.exit_ang, sel_cfg.entry_ang};
            endcase
         end
      end
      if (wr_fire) begin
         if (ctrl_hit) begin
            repeat_en_next = pwdata[`LDS_CTRL_REPEAT_EN];
            unit_ms_next = pwdata[`LDS_CTRL_UNIT_MS];
            trig_pol_next = pwdata[`LDS_CTRL_TRIG_POL];
            out_en_next = pwdata[`LDS_CTRL_OUT_EN];
            if (pwdata[`LDS_CMD_CLEAR]) begin
               for (int i = 0; i < 6; i++) begin
                  edit_next[i] = STEP_DEF;
               end
            end
            if (pwdata[`LDS_CMD_COMPILE]) begin
               act_next = edit_reg;
            end
         end else if (paddr == `LDS_OFF_REPEAT) begin
            // values above the maximum saturate rather than wrap
            repeat_cnt_next = (pwdata[31:0] > REPEAT_MAX) ? 14'(REPEAT_MAX) : pwdata[13:0];
         end else if (paddr == `LDS_OFF_TRIGW) begin
            trig_w_next = pwdata[15:0];
         end else if (step_hit) begin
            unique case (wr_word)
               `LDS_STEP_WORD_CTL: begin
                  w.code = pwdata[`LDS_STEP_CODE_LSB +: 2];
                  w.trig_en = pwdata[`LDS_STEP_TRIG_BIT];
                  w.entry_en = pwdata[`LDS_STEP_ENTRY_BIT];
                  w.exit_en = pwdata[`LDS_STEP_EXIT_BIT];
                  w.duration = pwdata[`LDS_STEP_HI_LSB +: 16];
               end
               `LDS_STEP_WORD_VF: begin
                  w.volt = pwdata[15:0];
                  w.freq = pwdata[`LDS_STEP_HI_LSB +: 16];
               end
               default: begin
                  w.entry_ang = pwdata[15:0];
                  w.exit_ang = pwdata[`LDS_STEP_HI_LSB +: 16];
               end
            endcase
            edit_next[wr_idx] = sanitize(wr_idx, w);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 6; i++) begin
            edit_reg[i] <= STEP_DEF;
            act_reg[i] <= STEP_DEF;
         end
         repeat_en_reg <= 1'b0;
         unit_ms_reg <= 1'b0;
         trig_pol_reg <= 1'b0;
         out_en_reg <= 1'b0;
         repeat_cnt_reg <= `LDS_DEF_REPEAT;
         trig_w_reg <= `LDS_DEF_TRIGW;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         edit_reg <= edit_next;
         act_reg <= act_next;
         repeat_en_reg <= repeat_en_next;
         unit_ms_reg <= unit_ms_next;
         trig_pol_reg <= trig_pol_next;
         out_en_reg <= out_en_next;
         repeat_cnt_reg <= repeat_cnt_next;
         trig_w_reg <= trig_w_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   // ----------------------------------------
   // step sequencer
   // ----------------------------------------
   logic [15:0] dur_reg, dur_next;
   logic [MSW-1:0] ms_cnt_reg, ms_cnt_next;
   logic [9:0] sec_cnt_reg, sec_cnt_next;
   logic [15:0] trig_cnt_reg, trig_cnt_next;
   lds_pkg::lds_out_type out_reg, out_next;

   always_comb begin
      lds_pkg::lds_step_type cur, nxt;
      lds_pkg::lds_state_type to;
      logic ms_tick, unit_tick, enter, adv, reached;
      logic [15:0] diff, el, va, vb, fa, fb;
      logic signed [33:0] vr, fr;
      cur = act_reg[step_idx(state_reg)];
      to = state_reg;
      enter = 1'b0;
      adv = 1'b0;
      state_next = state_reg;
      wait_next = wait_reg;
      rep_next = rep_reg;
      dur_next = dur_reg;
      out_next = out_reg;
      // prescaler restarts on each step entry so the first unit is a full one
      ms_tick = ms_cnt_reg == MSW'(MS_CYCLES - 1);
      ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 1'b1;
      sec_cnt_next = ms_tick ? ((sec_cnt_reg == 10'(`LDS_MS_PER_S - 1)) ? 10'h000 : sec_cnt_reg + 10'h001)
                             : sec_cnt_reg;
      unit_tick = unit_ms_reg ? ms_tick : (ms_tick && sec_cnt_reg == 10'(`LDS_MS_PER_S - 1));
      trig_cnt_next = (trig_cnt_reg != 16'h0000) ? trig_cnt_reg - 16'h0001 : trig_cnt_reg;
      diff = cur.exit_ang - out_reg.phase;
      // the accumulator steps by freq, so the target is hit when it lies within one step
      reached = diff <= out_reg.freq;
      if (state_reg == lds_pkg::LDS_IDLE) begin
         if (start_cmd && out_en_reg) begin
            to = lds_pkg::LDS_PRE;
            rep_next = 14'h0000;
            enter = 1'b1;
         end
      end else if (exit_cmd) begin
         to = lds_pkg::LDS_IDLE;
         enter = 1'b1;
      end else if (wait_reg) begin
         adv = reached;
      end else if (dur_reg == 16'h0000) begin
         if (cur.exit_en && !reached) begin
            wait_next = 1'b1;
         end else begin
            adv = 1'b1;
         end
      end else if (unit_tick) begin
         dur_next = dur_reg - 16'h0001;
      end
      if (adv) begin
         enter = 1'b1;
         unique case (state_reg)
            lds_pkg::LDS_PRE: to = lds_pkg::LDS_FALL;
            lds_pkg::LDS_FALL: to = lds_pkg::LDS_FAULT;
            lds_pkg::LDS_FAULT: to = lds_pkg::LDS_RECOV;
            lds_pkg::LDS_RECOV: to = lds_pkg::LDS_POST;
            default: begin
               if (!repeat_en_reg) begin
                  to = lds_pkg::LDS_IDLE;
               end else if (repeat_cnt_reg == 14'h0000) begin
                  to = lds_pkg::LDS_PRE;
               end else if (rep_reg >= repeat_cnt_reg) begin
                  to = lds_pkg::LDS_IDLE;
               end else begin
                  rep_next = rep_reg + 14'h0001;
                  to = lds_pkg::LDS_PRE;
               end
            end
         endcase
      end
      nxt = act_reg[step_idx(to)];
      if (enter) begin
         state_next = to;
         wait_next = 1'b0;
         dur_next = (to == lds_pkg::LDS_IDLE) ? 16'h0000 : nxt.duration;
         ms_cnt_next = '0;
         sec_cnt_next = 10'h000;
         if (nxt.trig_en && to != lds_pkg::LDS_IDLE) begin
            trig_cnt_next = trig_w_reg;
         end
      end
      // voltage and frequency of the step in force next cycle
      va = act_reg[1].volt;
      vb = act_reg[3].volt;
      fa = act_reg[1].freq;
      fb = act_reg[3].freq;
      el = nxt.duration - dur_next;
      vr = 34'sd0;
      fr = 34'sd0;
      unique case (state_next)
         lds_pkg::LDS_IDLE: begin
            out_next.volt = act_reg[0].volt;
            out_next.freq = act_reg[0].freq;
         end
         lds_pkg::LDS_PRE, lds_pkg::LDS_POST: begin
            out_next.volt = va;
            out_next.freq = fa;
         end
         lds_pkg::LDS_FAULT: begin
            out_next.volt = vb;
            out_next.freq = fb;
         end
         default: begin
            // combinational divide trades area for an exact linear sweep
            if (nxt.duration != 16'h0000) begin
               if (state_next == lds_pkg::LDS_FALL) begin
                  vr = ((34'($signed({1'b0, vb})) - 34'($signed({1'b0, va}))) * 34'($signed({1'b0, el})))
                       / 34'($signed({1'b0, nxt.duration}));
                  fr = ((34'($signed({1'b0, fb})) - 34'($signed({1'b0, fa}))) * 34'($signed({1'b0, el})))
                       / 34'($signed({1'b0, nxt.duration}));
                  out_next.volt = va + vr[15:0];
                  out_next.freq = fa + fr[15:0];
               end else begin
                  vr = ((34'($signed({1'b0, va})) - 34'($signed({1'b0, vb}))) * 34'($signed({1'b0, el})))
                       / 34'($signed({1'b0, nxt.duration}));
                  fr = ((34'($signed({1'b0, fa})) - 34'($signed({1'b0, fb}))) * 34'($signed({1'b0, el})))
                       / 34'($signed({1'b0, nxt.duration}));
                  out_next.volt = vb + vr[15:0];
                  out_next.freq = fb + fr[15:0];
               end
            end
         end
      endcase
      out_next.code = nxt.code;
      out_next.trig = (trig_cnt_next != 16'h0000) ^ trig_pol_reg;
      if (enter && nxt.entry_en) begin
         out_next.phase = nxt.entry_ang;
      end else begin
         out_next.phase = out_reg.phase + out_reg.freq;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= lds_pkg::LDS_IDLE;
         wait_reg <= 1'b0;
         rep_reg <= 14'h0000;
         dur_reg <= 16'h0000;
         ms_cnt_reg <= '0;
         sec_cnt_reg <= 10'h000;
         trig_cnt_reg <= 16'h0000;
         out_reg <= '{code: `LDS_DEF_CODE, trig: 1'b0, volt: `LDS_DEF_VOLT,
                      freq: `LDS_DEF_FREQ, phase: `LDS_DEF_ANGLE};
         run_active <= 1'b0;
         output_on <= 1'b0;
         balanced_mode <= 1'b1;
         internal_sine_src <= 1'b1;
      end else if (clk_en) begin
         state_reg <= state_next;
         wait_reg <= wait_next;
         rep_reg <= rep_next;
         dur_reg <= dur_next;
         ms_cnt_reg <= ms_cnt_next;
         sec_cnt_reg <= sec_cnt_next;
         trig_cnt_reg <= trig_cnt_next;
         out_reg <= out_next;
         run_active <= state_next != lds_pkg::LDS_IDLE;
         output_on <= out_en_next;
         balanced_mode <= 1'b1;
         internal_sine_src <= 1'b1;
      end
   end

   assign sig_out = out_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

endmodule

`default_nettype wire
